//--- bench/pfgm_pin_model.sv
// Far side of the port F pins: wire level from drivers, pull-ups and a floating level
`timescale 1ns/100ps
module pfgm_pin_model
(
   input wire logic [7:0] i_nch_on,
   input wire logic [7:0] i_pch_on,
   input wire logic [7:0] i_pull_on,
   input wire logic [7:0] i_float,
   output wire logic [7:0] o_pin
);
   // Low driver wins; an undriven line without pull-up shows a random level, never a stale one
   assign o_pin = ~i_nch_on & (i_pch_on | i_pull_on | i_float);
endmodule // pfgm_pin_model

//--- bench/pfgm_port_f_bench.sv
// Self-checking random bench for the port F block
`timescale 1ns/100ps
module pfgm_port_f_bench;
   logic i_ref_clk = '0, i_reset_n = '0, i_wr = '0, i_rd = '0, i_hw_standby = '0;
   logic i_pwm_group_a_select = '0, i_pwm_group_b_select = '0, i_timer_out_select = '0;
   logic i_ext_timer_compare_out = '0;
   logic [3:0] i_addr = '0, i_pwm_channel_out_enable = '0, i_ext_pwm_out = '0;
   logic [3:0] i_timer_compare_out_mode = '0, i_irq_pin_select_bit = '0, i_irq_enable_bit = '0;
   logic [7:0] i_wdata = '0, fl = '0, dir, lat, typ, per, lvl, drv, nch, pch, pul, q, pv;
   logic [31:0] r;
   wire [7:0] i_pin, o_rdata, o_pin, o_pin_oe_n, o_nch_on, o_pch_on, o_pull_on;
   wire [3:0] o_ext_interrupt;
   integer seed = 80, mismatches = 0, checked = 0, n;
   pfgm_port_f DUT (.*);
   pfgm_pin_model u_pins (.i_nch_on(o_nch_on), .i_pch_on(o_pch_on), .i_pull_on(o_pull_on),
      .i_float(fl), .o_pin(i_pin));
   // 250 MHz reference clock
   always #2 i_ref_clk = ~i_ref_clk;
   task chk(input [7:0] s, e, input string nm);
      checked++;
      if (s !== e)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   // One strobe cycle, then an idle cycle; read data is caught in the idle cycle
   task bus(input w, input [3:0] a, input [7:0] d);
      i_wr <= w;
      i_rd <= !w;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_ref_clk);
      i_wr <= '0;
      i_rd <= '0;
      #1 q = o_rdata;
      @(posedge i_ref_clk);
   endtask
   task stop_test;
      if (mismatches == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   function [7:0] rnd(input c);
      rnd = c ? 8'hff : 8'($random(seed));
   endfunction
   // Reset, latch reset value, then random register and peripheral settings
   initial
   begin
      repeat (16) @(posedge i_ref_clk);
      i_reset_n <= 1'h1;
      bus(0, 4'h4, 8'h00);
      chk(q, 8'h00, "latch reset");
      for (n = 0; n < 200; n++)
      begin
         r = $random(seed);
         {i_pwm_group_a_select, i_pwm_group_b_select, i_timer_out_select,
            i_ext_timer_compare_out} <= r[31:28];
         fl <= r[27:20];
         {i_pwm_channel_out_enable, i_ext_pwm_out, i_timer_compare_out_mode,
            i_irq_pin_select_bit, i_irq_enable_bit} <= r[19:0];
         i_hw_standby <= n % 5 == 4;
         dir = rnd(n == 0);
         lat = rnd(n < 2);
         typ = rnd(n == 1);
         bus(1, 4'h0, dir);
         bus(1, 4'h4, lat);
         bus(0, 4'h4, 8'h00);
         chk(q, lat, "latch");
         bus(1, 4'h8, typ);
         bus(0, 4'h8, 8'h00);
         chk(q, typ, "type");
         bus(0, 4'h2, 8'h00);
         chk(q, 8'h00, "unmapped");
         // Expected drive: peripheral takes the pin only where its selects allow
         per = {{{2{i_pwm_group_a_select}}, {2{i_pwm_group_b_select}}} & dir[7:4]
            & i_pwm_channel_out_enable, i_timer_out_select && |i_timer_compare_out_mode, 3'h0};
         lvl = (lat & ~per) | ({i_ext_pwm_out, i_ext_timer_compare_out, 3'h0} & per);
         drv = dir | per;
         nch = drv & ~lvl;
         pch = drv & lvl & ~typ;
         pul = ~dir & lat & {8{!i_hw_standby}};
         pv = ~nch & (pch | pul | fl);
         bus(0, 4'h0, 8'h00);
         chk(q, pv, "pins");
         #1;
         chk(o_nch_on, nch, "nch");
         chk(o_pch_on, pch, "pch");
         chk(o_pull_on, pul, "pull");
         chk(o_pin_oe_n, ~drv, "oe_n");
         chk(o_pin, lvl, "level");
         chk({4'h0, o_ext_interrupt}, {4'h0, pv[3:0] & ~i_irq_pin_select_bit
            & i_irq_enable_bit}, "irq");
         bus(0, 4'hc, 8'h00);
         chk(q, per, "status");
         @(posedge i_ref_clk);
      end
      stop_test;
   end
endmodule // pfgm_port_f_bench

//--- bench/pfgm_port_f_sva.sv
// Checker for the port F block, bound to its top module
`timescale 1ns/100ps
module pfgm_port_f_sva
(
   input wire logic i_ref_clk, i_reset_n, i_wr, i_rd, i_hw_standby,
   input wire logic i_timer_out_select, i_ext_timer_compare_out,
   input wire logic [3:0] i_addr, i_timer_compare_out_mode, i_irq_pin_select_bit,
   input wire logic [3:0] i_irq_enable_bit, o_ext_interrupt,
   input wire logic [7:0] i_wdata, o_rdata, i_pin, o_nch_on, o_pch_on, o_pull_on
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);
   // Latch write, one idle cycle, then its read-back
   sequence s_lat_wr; i_wr && i_addr == 4'h4; endsequence
   sequence s_lat_rd; i_rd && i_addr == 4'h4; endsequence
   AST_LAT_BACK: assert property (s_lat_wr ##2 s_lat_rd |=> o_rdata == $past(i_wdata, 3))
      else $error("latch read-back wrong");
   AST_PIN_READ: assert property (i_rd && i_addr == 4'h0 |=> o_rdata == $past(i_pin))
      else $error("pin level read wrong");
   AST_DRV_EXCL: assert property ((o_nch_on & o_pch_on) == 8'h00)
      else $error("both drivers on");
   AST_STBY_PULL: assert property (i_hw_standby |-> o_pull_on == 8'h00)
      else $error("pull-up on in standby");
   // Pin 3 may drive for the timer while its direction bit is 0, so it is left out
   AST_PULL_OUT: assert property (((o_nch_on | o_pch_on) & o_pull_on & 8'hf7) == 8'h00)
      else $error("pull-up on driven pin");
   AST_IRQ_GATE: assert property (o_ext_interrupt ==
      (i_pin[3:0] & i_irq_enable_bit & ~i_irq_pin_select_bit)) else $error("irq gating wrong");
   AST_TMO: assert property (i_timer_out_select && i_timer_compare_out_mode != 4'h0
      |-> o_nch_on[3] != i_ext_timer_compare_out) else $error("timer output not driven");
   AST_OD_PCH: assert property (i_wr && i_addr == 4'h8 && i_wdata == 8'hff
      |=> o_pch_on == 8'h00) else $error("p-driver on in open drain");
endmodule // pfgm_port_f_sva
bind pfgm_port_f pfgm_port_f_sva u_sva (.*);

//--- core/pfgm_pin_cell.v
// One pin of port F: driver and pull-up control for a chosen output level
`timescale 1ns/100ps
module pfgm_pin_cell
(
   input wire i_drive_en,
   input wire i_level,
   input wire i_open_drain,
   input wire i_dir,
   input wire i_latch,
   input wire i_pull_block,
   output wire o_nch_on,
   output wire o_pch_on,
   output wire o_pull_on
);

   // A driven low level always sinks; a driven high level sources only in push-pull mode
   assign o_nch_on = i_drive_en & ~i_level;
   assign o_pch_on = i_drive_en & i_level & ~i_open_drain;

   // Pull-up only where the direction bit is 0 and the latch holds one; blocked in reset/standby
   assign o_pull_on = ~i_pull_block & ~i_dir & i_latch;

endmodule // pfgm_pin_cell

//--- core/pfgm_port_f.v
// Port F: eight-bit I/O port with pin multiplexer for PWM, timer and interrupts
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`include "pfgm_defines.vh"
module pfgm_port_f
(
   input wire i_ref_clk,
   input wire i_reset_n,
   // Register port
   input wire [`PFGM_ADDR_W-1:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [7:0] o_rdata,
   // Operating mode
   input wire i_hw_standby,
   // Function selects and peripheral outputs from the owning units
   input wire i_pwm_group_a_select,
   input wire i_pwm_group_b_select,
   input wire [3:0] i_pwm_channel_out_enable,
   input wire [3:0] i_ext_pwm_out,
   input wire i_timer_out_select,
   input wire [3:0] i_timer_compare_out_mode,
   input wire i_ext_timer_compare_out,
   input wire [3:0] i_irq_pin_select_bit,
   input wire [3:0] i_irq_enable_bit,
   // Pins
   input wire [7:0] i_pin,
   output wire [7:0] o_pin,
   output wire [7:0] o_pin_oe_n,
   output wire [7:0] o_nch_on,
   output wire [7:0] o_pch_on,
   output wire [7:0] o_pull_on,
   // Interrupt inputs 11..8 toward the interrupt controller
   output wire [3:0] o_ext_interrupt
);

   reg [7:0] port_out_latch;
   reg [7:0] port_direction;
   reg [7:0] port_driver_type;
   reg [7:0] next_rdata;
   reg [7:0] periph_sel;
   reg [7:0] periph_level;
   reg [15:0] fn_code;
   reg pull_block;
   wire [7:0] drive_en;
   wire [7:0] drive_level;
   wire [3:0] pwm_sel;
   integer k;
   // Second loop index, so each combinational process owns its own variable
   integer j;

   // Software registers; direction is write-only and shares its slot
   always @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         port_out_latch <= `PFGM_RST_OUT_LATCH;
         port_direction <= `PFGM_RST_DIR;
         port_driver_type <= `PFGM_RST_DRV_TYPE;
      end
      else if (i_wr)
      begin
         case (i_addr)
            `PFGM_OFS_DIR_PIN: port_direction <= i_wdata;
            `PFGM_OFS_OUT_LATCH: port_out_latch <= i_wdata;
            `PFGM_OFS_DRV_TYPE: port_driver_type <= i_wdata;
            default: port_out_latch <= port_out_latch;
         endcase
      end
   end

   // Pull-up hold-off: set by reset, released at the first edge after it
   always @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         pull_block <= 1'b1;
      else
         pull_block <= 1'b0;
   end

   // Read mux; pins are synchronous inputs, sampled at the read edge
   always @*
   begin
      next_rdata = 8'h00;
      case (i_addr)
         `PFGM_OFS_DIR_PIN: next_rdata = i_pin;
         `PFGM_OFS_OUT_LATCH: next_rdata = port_out_latch;
         `PFGM_OFS_DRV_TYPE: next_rdata = port_driver_type;
         `PFGM_OFS_STATUS: next_rdata = periph_sel;
         default: next_rdata = 8'h00;
      endcase
   end

   // Read data stands only in the cycle after the read strobe
   always @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         o_rdata <= 8'h00;
      else if (i_rd)
         o_rdata <= next_rdata;
      else
         o_rdata <= 8'h00;
   end

   // PWM group select per pin: a for 7,6 and b for 5,4
   assign pwm_sel = {i_pwm_group_a_select, i_pwm_group_a_select,
                     i_pwm_group_b_select, i_pwm_group_b_select};

   // Peripheral hand-over, purely combinational so unit changes act at once
   always @*
   begin
      periph_sel = 8'h00;
      periph_level = 8'h00;
      for (k = 0; k < 4; k = k + 1)
      begin
         // Direction 1 and enable 1 with group select gives the PWM channel
         periph_sel[4+k] = pwm_sel[k] & port_direction[4+k]
                           & i_pwm_channel_out_enable[k];
         periph_level[4+k] = i_ext_pwm_out[k];
      end
      // Timer compare wins over the direction bit
      periph_sel[`PFGM_PIN_TMO] = i_timer_out_select
                                  & (|i_timer_compare_out_mode);
      periph_level[`PFGM_PIN_TMO] = i_ext_timer_compare_out;
   end

   // Two-bit function code per pin, for debug visibility
   always @*
   begin
      fn_code = 16'h0000;
      for (j = 0; j < 8; j = j + 1)
      begin
         if (periph_sel[j])
            fn_code[2*j +: 2] = `PFGM_FN_PERIPH;
         else if (port_direction[j])
            fn_code[2*j +: 2] = `PFGM_FN_OUTPUT;
         else
            fn_code[2*j +: 2] = `PFGM_FN_INPUT;
      end
   end

   // The timer output drives pin 3 even if its direction bit is clear; PWM pins also need direction 1
   assign drive_en = port_direction | periph_sel;
   assign drive_level = (periph_sel & periph_level) | (~periph_sel & port_out_latch);
   assign o_pin = drive_level;
   assign o_pin_oe_n = ~drive_en;

   // Interrupt inputs see the pin alongside any port function
   assign o_ext_interrupt = i_pin[3:0] & ~i_irq_pin_select_bit & i_irq_enable_bit;

   // Per-pin driver and pull-up cells
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1)
      begin : pin_cells
         pfgm_pin_cell u_cell
         (
            .i_drive_en(drive_en[g]),
            .i_level(drive_level[g]),
            .i_open_drain(port_driver_type[g]),
            .i_dir(port_direction[g]),
            .i_latch(port_out_latch[g]),
            .i_pull_block(pull_block | i_hw_standby),
            .o_nch_on(o_nch_on[g]),
            .o_pch_on(o_pch_on[g]),
            .o_pull_on(o_pull_on[g])
         );
      end
   endgenerate

   // Hidden debug code only feeds an unused wire; the status read shows the periph_sel bits, one bit per pin
   wire fn_unused = |fn_code;

endmodule // pfgm_port_f

//--- include/pfgm_defines.vh
// Register offsets, field positions and reset values of the port F block
`ifndef PFGM_DEFINES_VH
`define PFGM_DEFINES_VH

// Register offsets (byte addresses on the plain register port)
`define PFGM_ADDR_W 4
`define PFGM_OFS_DIR_PIN 4'h0
`define PFGM_OFS_OUT_LATCH 4'h4
`define PFGM_OFS_DRV_TYPE 4'h8
`define PFGM_OFS_STATUS 4'hc

// Reset values
`define PFGM_RST_OUT_LATCH 8'h00
`define PFGM_RST_DIR 8'h00
`define PFGM_RST_DRV_TYPE 8'h00

// Pin positions with shared functions
`define PFGM_PIN_PWM15 7
`define PFGM_PIN_PWM14 6
`define PFGM_PIN_PWM13 5
`define PFGM_PIN_PWM12 4
`define PFGM_PIN_TMO 3
`define PFGM_PIN_EXT_INTERRUPT_11 3

// Pin function codes in the debug fn_code vector, two bits per pin
`define PFGM_FN_INPUT 2'h0
`define PFGM_FN_OUTPUT 2'h1
`define PFGM_FN_PERIPH 2'h2

`endif
